/* hw/rwc_defines.vh */
// offsets, fields, values and timing for the reset and wake control block
`ifndef RWC_DEFINES_VH
`define RWC_DEFINES_VH
// ==========================================
// register byte offsets
`define RWC_PWR_CTL 8'h00
`define RWC_INTERRUPT_STATUS_REG 8'h04
`define RWC_INT_EN 8'h08
`define RWC_HARDWARE_CONFIG_REG 8'h0C
`define RWC_BYTE_TST 8'h10
`define RWC_EEPROM_COMMAND_REG 8'h14
`define RWC_PHY_CTL 8'h18
`define RWC_PHY_STS 8'h1C
`define RWC_PHY_MODE 8'h20
`define RWC_PHY_INT 8'h24
`define RWC_PHY_MSK 8'h28
`define RWC_STRAP 8'h2C
// ==========================================
// power control fields
`define RWC_PC_READY 0
`define RWC_PC_PME_EN 1
`define RWC_PC_PULSE 3
`define RWC_PC_WSF_LO 4
`define RWC_PC_WSF_HI 5
`define RWC_PC_ENERGY_WAKE_ENABLE 8
`define RWC_PC_WF_EN 9
`define RWC_PC_PHY_RST 10
`define RWC_PC_PM_LO 12
`define RWC_PC_PM_HI 13
// other fields
`define RWC_IS_WAKE 0
`define RWC_HC_SOFT_RESET_BIT 0
`define RWC_E2P_BUSY 31
`define RWC_PHC_RST 15
`define RWC_PHC_PD 11
`define RWC_PHS_LINK 2
`define RWC_PHM_EDPD 13
`define RWC_PHM_EON 1
`define RWC_PHI_EON 1
// ==========================================
// values
`define RWC_WSF_FRAME 2'b10
`define RWC_WSF_ENERGY 2'b01
`define RWC_PM_D0 2'b00
`define RWC_PM_D1 2'b01
`define RWC_PM_D2 2'b10
`define RWC_BYTE_PAT 32'h1234_5678
// ==========================================
// timing
`define RWC_CLK_MHZ 100
`define RWC_POR_MS 22
`define RWC_PULSE_MS 50
`define RWC_WAKE_MS 2
`define RWC_SOFT_RESET_BIT_US 2
`define RWC_PHYRST_US 100
`define RWC_PIN_US 1
`define RWC_POR_CYC (`RWC_POR_MS * 1000 * `RWC_CLK_MHZ)
`define RWC_PULSE_CYC (`RWC_PULSE_MS * 1000 * `RWC_CLK_MHZ)
`define RWC_WAKE_CYC (`RWC_WAKE_MS * 1000 * `RWC_CLK_MHZ)
`define RWC_SOFT_RESET_BIT_CYC (`RWC_SOFT_RESET_BIT_US * `RWC_CLK_MHZ)
`define RWC_PHYRST_CYC (`RWC_PHYRST_US * `RWC_CLK_MHZ)
`define RWC_PIN_CYC (`RWC_PIN_US * `RWC_CLK_MHZ)
`endif

/* hw/rwc_top.v */
// reset sequencing, wake event and phy power control with apb registers
// What this block does
// [RULE_01] wake signal sets flag, enabled flag interrupts
// [RULE_02] flag holds while wake signal active
// [RULE_03] interrupt independent of pme enable and pin
// [RULE_04] pulse mode drives pin 50 ms
// [RULE_05] static mode drives pin until deactivated
// [RULE_06] pin drops on status, enable or pme clear
// [RULE_07] general power-down holds phy, release resets
// [RULE_08] energy mode powers down without line energy
// [RULE_09] no transmit while energy absent
// [RULE_10] energy return powers up, sets phy flag
// [RULE_11] por and pin reset clear everything
// [RULE_12] soft reset spares pll, phy, straps, retained
// [RULE_13] two phy soft resets touch phy only
// [RULE_14] eeprom busy after hard or soft reset
// [RULE_15] queued transmit held until link up
// [RULE_16] power-on hold 22 ms, then ready
// [RULE_17] pin reset clears ready until done
// [RULE_18] host treats 100 ms without ready as error
// [RULE_19] byte test wake sets ready within 2 ms
// [RULE_20] soft reset bit self-clears after 2 us
// [RULE_21] phy reset bit self-clears after 100 us
// [RULE_22] phy control reset bit self-clears when done
// [RULE_23] wake status 10b frame, 01b energy
// [RULE_24] in sleep only byte test write honoured
// [RULE_25] durations from counters with parameter counts
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
`include "rwc_defines.vh"

module rwc_top #(
  parameter CW = 23,
  parameter [22:0] POR_CYC = `RWC_POR_CYC,
  parameter [22:0] PULSE_CYC = `RWC_PULSE_CYC,
  parameter [22:0] WAKE_CYC = `RWC_WAKE_CYC,
  parameter [22:0] PHYRST_CYC = `RWC_PHYRST_CYC,
  parameter NSTRAP = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reset_pin_n,
  input wire line_energy_pin,
  input wire link_status_pin,
  input wire [NSTRAP-1:0] strap_pins,
  input wire wake_frame_det,
  input wire eeprom_done,
  output reg pme_pin,
  output reg host_irq,
  output reg pll_rst,
  output reg hbi_rst,
  output reg soft_reset_retained_rst,
  output reg mil_rst,
  output reg mac_rst,
  output reg phy_rst,
  output reg eeprom_reload,
  output reg phy_power_down,
  output reg phy_tx_en,
  output reg tx_hold
);

  localparam NPIN = NSTRAP + 3;
  localparam [22:0] SOFT_RESET_BIT_CYC = `RWC_SOFT_RESET_BIT_CYC;
  localparam [22:0] PIN_CYC = `RWC_PIN_CYC;

  // ==========================================
  // pin synchronisers
  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] s1;
  reg [NPIN-1:0] s2;
  reg [NPIN-1:0] s3;
  reg [NPIN-1:0] filt;
  assign pin_raw = {strap_pins, link_status_pin, line_energy_pin, reset_pin_n};

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[g] <= 1'b1;
          s2[g] <= 1'b1;
          s3[g] <= 1'b1;
          filt[g] <= 1'b1;
        end else begin
          s1[g] <= pin_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            filt[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  wire pin_n = filt[0];
  wire energy = filt[1];
  wire link = filt[2];
  wire [NSTRAP-1:0] straps = filt[NPIN-1:3];

  function is_mapped;
    input [7:0] a;
    begin
      if (a[1:0] != 2'b00) begin
        is_mapped = 1'b0;
      end else if (a <= `RWC_STRAP) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction

  // ==========================================
  // state
  reg [CW-1:0] hard_cnt;
  reg [CW-1:0] soft_reset_bit_cnt;
  reg [CW-1:0] phy_cnt;
  reg [CW-1:0] wake_cnt;
  reg [CW-1:0] pme_cnt;
  reg ready;
  reg pme_en;
  reg pulse_sel;
  reg [1:0] wsf;
  reg energy_wake_enable;
  reg wf_en;
  reg pc_phy_rst;
  reg [1:0] pm_mode;
  reg wake_flag;
  reg int_en;
  reg soft_reset_bit_bit;
  reg e2p_busy;
  reg phc_rst;
  reg phc_pd;
  reg edpd;
  reg phy_flag;
  reg phy_msk;
  reg [NSTRAP-1:0] strap_lat;
  reg wake_q;
  reg energy_q;

  wire hard_busy = (hard_cnt != {CW{1'b0}});
  wire sleep = (pm_mode != `RWC_PM_D0);
  wire wake_sig = (wsf[1] & wf_en) | (wsf[0] & energy_wake_enable);
  wire wake_evt = wake_sig & ~wake_q;
  wire wr = psel & penable & pwrite & pready;
  wire wr_ok = wr & (~sleep | (paddr == `RWC_BYTE_TST)); // [RULE_24]
  wire w_pc = wr_ok & (paddr == `RWC_PWR_CTL);
  wire w_is = wr_ok & (paddr == `RWC_INTERRUPT_STATUS_REG);
  wire w_hc = wr_ok & (paddr == `RWC_HARDWARE_CONFIG_REG);
  wire w_pcl = wr_ok & (paddr == `RWC_PHY_CTL);
  wire w_pm = wr_ok & (paddr == `RWC_PHY_MODE);
  wire w_pi = wr_ok & (paddr == `RWC_PHY_INT);
  wire phy_start = (w_pc & pwdata[`RWC_PC_PHY_RST]) | (w_pcl & pwdata[`RWC_PHC_RST]) |
                   (w_pcl & phc_pd & ~pwdata[`RWC_PHC_PD]);
  wire soft_reset_bit_start = w_hc & pwdata[`RWC_HC_SOFT_RESET_BIT];
  wire [1:0] wsf_set = {wake_frame_det & (pm_mode == `RWC_PM_D1),
                        energy & (pm_mode == `RWC_PM_D2)};

  // ==========================================
  // read mux
  reg [31:0] next_prdata;
  reg next_slverr;
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = ~is_mapped(paddr);
    if (sleep && paddr != `RWC_PWR_CTL) begin
      next_prdata = 32'h0000_0000;
    end else if (paddr == `RWC_PWR_CTL) begin
      next_prdata[`RWC_PC_READY] = ready;
      next_prdata[`RWC_PC_PME_EN] = pme_en;
      next_prdata[`RWC_PC_PULSE] = pulse_sel;
      next_prdata[`RWC_PC_WSF_HI:`RWC_PC_WSF_LO] = wsf;
      next_prdata[`RWC_PC_ENERGY_WAKE_ENABLE] = energy_wake_enable;
      next_prdata[`RWC_PC_WF_EN] = wf_en;
      next_prdata[`RWC_PC_PHY_RST] = pc_phy_rst;
      next_prdata[`RWC_PC_PM_HI:`RWC_PC_PM_LO] = pm_mode;
    end else if (paddr == `RWC_INTERRUPT_STATUS_REG) begin
      next_prdata[`RWC_IS_WAKE] = wake_flag;
    end else if (paddr == `RWC_INT_EN) begin
      next_prdata[`RWC_IS_WAKE] = int_en;
    end else if (paddr == `RWC_HARDWARE_CONFIG_REG) begin
      next_prdata[`RWC_HC_SOFT_RESET_BIT] = soft_reset_bit_bit;
    end else if (paddr == `RWC_BYTE_TST) begin
      next_prdata = `RWC_BYTE_PAT;
    end else if (paddr == `RWC_EEPROM_COMMAND_REG) begin
      next_prdata[`RWC_E2P_BUSY] = e2p_busy; // [RULE_14]
    end else if (paddr == `RWC_PHY_CTL) begin
      next_prdata[`RWC_PHC_RST] = phc_rst;
      next_prdata[`RWC_PHC_PD] = phc_pd;
    end else if (paddr == `RWC_PHY_STS) begin
      next_prdata[`RWC_PHS_LINK] = link;
    end else if (paddr == `RWC_PHY_MODE) begin
      next_prdata[`RWC_PHM_EDPD] = edpd;
      next_prdata[`RWC_PHM_EON] = energy;
    end else if (paddr == `RWC_PHY_INT) begin
      next_prdata[`RWC_PHI_EON] = phy_flag;
    end else if (paddr == `RWC_PHY_MSK) begin
      next_prdata[`RWC_PHI_EON] = phy_msk;
    end else if (paddr == `RWC_STRAP) begin
      next_prdata[NSTRAP-1:0] = strap_lat;
    end
  end

  // ==========================================
  // apb response
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_slverr;
      end
    end
  end

  // ==========================================
  // control registers and sequencers
  task clear_all;
    begin
      soft_reset_bit_cnt <= {CW{1'b0}};
      phy_cnt <= {CW{1'b0}};
      wake_cnt <= {CW{1'b0}};
      pme_cnt <= {CW{1'b0}};
      pme_pin <= 1'b0;
      pme_en <= 1'b0;
      pulse_sel <= 1'b0;
      wsf <= 2'b00;
      energy_wake_enable <= 1'b0;
      wf_en <= 1'b0;
      pc_phy_rst <= 1'b0;
      pm_mode <= `RWC_PM_D0;
      wake_flag <= 1'b0;
      int_en <= 1'b0;
      soft_reset_bit_bit <= 1'b0;
      e2p_busy <= 1'b0;
      phc_rst <= 1'b0;
      phc_pd <= 1'b0;
      edpd <= 1'b0;
      phy_flag <= 1'b0;
      phy_msk <= 1'b0;
      wake_q <= 1'b0;
      energy_q <= 1'b0;
    end
  endtask

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_cnt <= POR_CYC; // [RULE_16]
      strap_lat <= {NSTRAP{1'b0}};
      eeprom_reload <= 1'b0;
      tx_hold <= 1'b1;
      clear_all;
    end else if (!pin_n) begin
      hard_cnt <= PIN_CYC; // [RULE_17]
      eeprom_reload <= 1'b0;
      tx_hold <= 1'b1;
      clear_all; // [RULE_11]
    end else if (hard_busy) begin
      hard_cnt <= hard_cnt - 1'b1;
      eeprom_reload <= 1'b0;
      if (hard_cnt == 1) begin
        strap_lat <= straps; // [RULE_11]
        eeprom_reload <= 1'b1;
        e2p_busy <= 1'b1; // [RULE_14]
        phy_cnt <= PHYRST_CYC;
      end
    end else begin
      eeprom_reload <= soft_reset_bit_start; // [RULE_12]
      wake_q <= wake_sig;
      energy_q <= energy;
      // eeprom busy, set wins over done
      if (soft_reset_bit_start) begin
        e2p_busy <= 1'b1; // [RULE_14]
      end else if (eeprom_done) begin
        e2p_busy <= 1'b0;
      end
      // power control writes
      if (w_pc) begin
        pme_en <= pwdata[`RWC_PC_PME_EN];
        pulse_sel <= pwdata[`RWC_PC_PULSE];
        energy_wake_enable <= pwdata[`RWC_PC_ENERGY_WAKE_ENABLE];
        wf_en <= pwdata[`RWC_PC_WF_EN];
        pm_mode <= pwdata[`RWC_PC_PM_HI:`RWC_PC_PM_LO];
      end else if (wr_ok && sleep && paddr == `RWC_BYTE_TST) begin
        pm_mode <= `RWC_PM_D0; // [RULE_24]
        wake_cnt <= WAKE_CYC; // [RULE_19]
      end else if (wake_cnt != {CW{1'b0}}) begin
        wake_cnt <= wake_cnt - 1'b1; // [RULE_25]
      end
      // wake status: write one clears, detection wins
      if (w_pc) begin
        wsf <= (wsf & ~pwdata[`RWC_PC_WSF_HI:`RWC_PC_WSF_LO]) | wsf_set; // [RULE_23]
      end else begin
        wsf <= wsf | wsf_set; // [RULE_23]
      end
      // wake flag held while wake signal active
      if (wake_sig) begin
        wake_flag <= 1'b1; // [RULE_01]
      end else if (w_is && pwdata[`RWC_IS_WAKE]) begin
        wake_flag <= 1'b0; // [RULE_02]
      end
      // external event pin
      if (!wake_sig || !pme_en) begin
        pme_pin <= 1'b0; // [RULE_06]
        pme_cnt <= {CW{1'b0}};
      end else if (wake_evt) begin
        pme_pin <= 1'b1; // [RULE_05]
        pme_cnt <= pulse_sel ? PULSE_CYC : {CW{1'b0}}; // [RULE_04]
      end else if (pme_cnt != {CW{1'b0}}) begin
        pme_cnt <= pme_cnt - 1'b1; // [RULE_25]
        if (pme_cnt == 1) begin
          pme_pin <= 1'b0; // [RULE_04]
        end
      end
      // soft reset
      if (soft_reset_bit_start) begin
        soft_reset_bit_bit <= 1'b1; // [RULE_20]
        soft_reset_bit_cnt <= SOFT_RESET_BIT_CYC;
        int_en <= 1'b0; // [RULE_12]
      end else begin
        if (wr_ok && paddr == `RWC_INT_EN) begin
          int_en <= pwdata[`RWC_IS_WAKE];
        end
        if (soft_reset_bit_cnt != {CW{1'b0}}) begin
          soft_reset_bit_cnt <= soft_reset_bit_cnt - 1'b1;
          if (soft_reset_bit_cnt == 1) begin
            soft_reset_bit_bit <= 1'b0; // [RULE_20]
          end
        end
      end
      // phy control and soft resets
      if (w_pcl) begin
        phc_pd <= pwdata[`RWC_PHC_PD]; // [RULE_07]
      end
      if (w_pm) begin
        edpd <= pwdata[`RWC_PHM_EDPD]; // [RULE_08]
      end
      if (wr_ok && paddr == `RWC_PHY_MSK) begin
        phy_msk <= pwdata[`RWC_PHI_EON];
      end
      if (edpd && energy && !energy_q) begin
        phy_flag <= 1'b1; // [RULE_10]
      end else if (w_pi && pwdata[`RWC_PHI_EON]) begin
        phy_flag <= 1'b0;
      end
      if (phy_start) begin
        phy_cnt <= PHYRST_CYC; // [RULE_13]
        pc_phy_rst <= w_pc & pwdata[`RWC_PC_PHY_RST]; // [RULE_21]
        phc_rst <= w_pcl & pwdata[`RWC_PHC_RST]; // [RULE_22]
      end else if (phy_cnt != {CW{1'b0}}) begin
        phy_cnt <= phy_cnt - 1'b1; // [RULE_25]
        if (phy_cnt == 1) begin
          pc_phy_rst <= 1'b0; // [RULE_21]
          phc_rst <= 1'b0; // [RULE_22]
        end
      end
      // transmit hold after any phy reset
      if (phy_start) begin
        tx_hold <= 1'b1; // [RULE_15]
      end else if (link && phy_cnt == {CW{1'b0}}) begin
        tx_hold <= 1'b0; // [RULE_15]
      end
    end
  end

  // ==========================================
  // registered reset, power and status outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready <= 1'b0;
      host_irq <= 1'b0;
      pll_rst <= 1'b1;
      hbi_rst <= 1'b1;
      soft_reset_retained_rst <= 1'b1;
      mil_rst <= 1'b1;
      mac_rst <= 1'b1;
      phy_rst <= 1'b1;
      phy_power_down <= 1'b0;
      phy_tx_en <= 1'b0;
    end else begin
      ready <= pin_n & ~hard_busy & ~sleep & (wake_cnt == {CW{1'b0}}); // [RULE_16]
      host_irq <= (wake_flag & int_en) | (phy_flag & phy_msk); // [RULE_03]
      pll_rst <= ~pin_n | hard_busy; // [RULE_11]
      soft_reset_retained_rst <= ~pin_n | hard_busy;
      hbi_rst <= ~pin_n | hard_busy | soft_reset_bit_bit; // [RULE_12]
      mil_rst <= ~pin_n | hard_busy | soft_reset_bit_bit;
      mac_rst <= ~pin_n | hard_busy | soft_reset_bit_bit;
      phy_rst <= ~pin_n | hard_busy | (phy_cnt != {CW{1'b0}}); // [RULE_13]
      phy_power_down <= phc_pd | (edpd & ~energy); // [RULE_08]
      phy_tx_en <= pin_n & ~hard_busy & ~phc_pd & ~(edpd & ~energy) &
                   (phy_cnt == {CW{1'b0}}); // [RULE_09]
    end
  end

endmodule // rwc_top

/* tb/rwc_far.sv */
// line, link and eeprom model on the far side
`timescale 1ns/1ns
// ==========
module rwc_far (
  input wire pclk,
  input wire presetn,
  input wire eeprom_reload,
  input wire frame_req,
  input wire line_on,
  output logic wake_frame_det,
  output logic line_energy_pin,
  output logic link_status_pin,
  output logic eeprom_done
);
  int ecnt;
  int lcnt;
  logic freq_d;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecnt <= 0;
      lcnt <= 0;
      freq_d <= 0;
      wake_frame_det <= 0;
      line_energy_pin <= 0;
      link_status_pin <= 0;
      eeprom_done <= 0;
    end else begin
      freq_d <= frame_req;
      wake_frame_det <= frame_req && !freq_d;
      // load ends some time after reload
      eeprom_done <= (ecnt == 1);
      ecnt <= eeprom_reload ? 30 : (ecnt != 0 ? ecnt - 1 : 0);
      line_energy_pin <= line_on;
      // link trains a while after energy
      lcnt <= line_on ? (lcnt < 8 ? lcnt + 1 : 8) : 0;
      link_status_pin <= (lcnt == 8);
    end
  end
endmodule // rwc_far

/* tb/rwc_properties.sv */
// port checker for the reset and wake control block
`timescale 1ns/1ns
// ==========
module rwc_props #(
  parameter int PHYRST_CYC = 30
) (
  input wire pclk,
  input wire presetn,
  input wire pme_pin,
  input wire pll_rst,
  input wire hbi_rst,
  input wire soft_reset_retained_rst,
  input wire mil_rst,
  input wire mac_rst,
  input wire phy_rst,
  input wire eeprom_reload,
  input wire phy_power_down,
  input wire phy_tx_en,
  input wire tx_hold
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int scnt;
  int pcnt;
  // run lengths of soft and phy-only resets
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt <= 0;
      pcnt <= 0;
    end else begin
      scnt <= (hbi_rst && !pll_rst) ? scnt + 1 : 0;
      pcnt <= (phy_rst && !pll_rst) ? pcnt + 1 : 0;
    end
  end
  property p_hard;
    pll_rst |-> soft_reset_retained_rst && hbi_rst && mil_rst && mac_rst && phy_rst;
  endproperty
  property p_soft;
    hbi_rst && !pll_rst |-> mil_rst && mac_rst && !soft_reset_retained_rst;
  endproperty
  property p_end;
    $fell(pll_rst) |-> phy_rst ##[0:3] (eeprom_reload || $past(eeprom_reload));
  endproperty
  property p_eep;
    eeprom_reload |=> !eeprom_reload;
  endproperty
  property p_tx;
    phy_power_down [*2] |-> !phy_tx_en;
  endproperty
  property p_hold;
    $rose(phy_rst) |=> tx_hold [*3];
  endproperty
  property p_soft_reset_bit;
    $fell(hbi_rst) && !$past(pll_rst) |-> scnt >= 195 && scnt <= 205;
  endproperty
  property p_phy;
    $fell(phy_rst) && !$past(pll_rst) |-> pcnt >= PHYRST_CYC - 3 && pcnt <= PHYRST_CYC + 3;
  endproperty
  a_hard: assert property (p_hard)
    else $error("hard reset misses a domain");
  a_soft: assert property (p_soft)
    else $error("soft reset domains wrong");
  a_end: assert property (p_end)
    else $error("no reload or phy reset at hold end");
  a_eep: assert property (p_eep)
    else $error("reload pulse too long");
  a_tx: assert property (p_tx)
    else $error("transmit while powered down");
  a_hold: assert property (p_hold)
    else $error("tx not held after phy reset");
  a_soft_reset_bit: assert property (p_soft_reset_bit)
    else $error("soft reset length wrong");
  a_phy: assert property (p_phy)
    else $error("phy reset length wrong");
  cover property ($fell(hbi_rst) && !pll_rst);
  cover property ($rose(pme_pin));
  cover property (phy_power_down && !phy_tx_en);
endmodule // rwc_props

bind rwc_top rwc_props #(.PHYRST_CYC(PHYRST_CYC)) rwc_props_i (.pclk, .presetn, .pme_pin,
  .pll_rst, .hbi_rst, .soft_reset_retained_rst, .mil_rst, .mac_rst, .phy_rst, .eeprom_reload,
  .phy_power_down, .phy_tx_en, .tx_hold);

/* tb/rwc_top_tb.sv */
// self-checking bench for the reset and wake control block
`timescale 1ns/1ns
`include "rwc_defines.vh"
// ==========
module rwc_top_tb;
  localparam [22:0] POR = 23'h32;
  localparam [22:0] PUL = 23'h28;
  localparam [22:0] WAKE = 23'h14;
  localparam [22:0] PHYR = 23'h1e;
  logic pclk, presetn, psel, penable, pwrite, reset_pin_n, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pme_pin, host_irq, pll_rst, hbi_rst, soft_reset_retained_rst, mil_rst, mac_rst, phy_rst;
  logic eeprom_reload, phy_power_down, phy_tx_en, tx_hold, frame_req, line_on;
  logic wake_frame_det, line_energy_pin, link_status_pin, eeprom_done;
  logic [3:0] strap_pins;
  logic [31:0] cfg [3] = '{32'h0000_1202, 32'h0000_120a, 32'h0000_1200};
  int err_total, compares, cyc, t0, run, plen;
  rwc_top #(.POR_CYC(POR), .PULSE_CYC(PUL), .WAKE_CYC(WAKE), .PHYRST_CYC(PHYR)) rwc_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reset_pin_n, .line_energy_pin, .link_status_pin, .strap_pins,
    .wake_frame_det, .eeprom_done, .pme_pin, .host_irq, .pll_rst, .hbi_rst, .soft_reset_retained_rst,
    .mil_rst, .mac_rst, .phy_rst, .eeprom_reload, .phy_power_down, .phy_tx_en, .tx_hold);
  rwc_far rwc_far_i (.pclk, .presetn, .eeprom_reload, .frame_req, .line_on,
    .wake_frame_det, .line_energy_pin, .link_status_pin, .eeprom_done);
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // cycle count and pulse length monitor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    run <= pme_pin ? run + 1 : 0;
    if (!pme_pin && run != 0) plen <= run;
  end
  task chk(input [31:0] s, input [31:0] x);
    compares++;
    if (s !== x) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task xf(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task poll;
    q = 0;
    while (q[0] !== 1'b1 && cyc - t0 < 1000) xf(0, `RWC_PWR_CTL, 0);
    chk(cyc - t0 < 1000, 1);
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    results;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, frame_req} = 0;
    reset_pin_n = 1;
    line_on = 1;
    q = $urandom(32'h0000_8b44);
    strap_pins = $urandom;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t0 = cyc;
    xf(0, `RWC_PWR_CTL, 0);
    chk(q[0], 0);
    poll;
    chk(cyc - t0 >= POR && cyc - t0 <= POR + 8, 1);
    xf(0, `RWC_EEPROM_COMMAND_REG, 0);
    chk(q[31], 1);
    repeat (40) @(posedge pclk);
    xf(0, `RWC_EEPROM_COMMAND_REG, 0);
    chk(q[31], 0);
    xf(0, `RWC_STRAP, 0);
    chk(q[3:0], strap_pins);
    xf(0, 8'h30, 0);
    chk(e, 1);
    $display("test 1 done");
    xf(1, `RWC_INT_EN, $urandom | 1);
    xf(1, `RWC_HARDWARE_CONFIG_REG, 1);
    xf(0, `RWC_HARDWARE_CONFIG_REG, 0);
    chk(q[0], 1);
    chk({pll_rst, phy_rst, mac_rst}, 3'b001);
    repeat (210) @(posedge pclk);
    xf(0, `RWC_HARDWARE_CONFIG_REG, 0);
    chk(q[0], 0);
    xf(0, `RWC_INT_EN, 0);
    chk(q[0], 0);
    $display("test 2 done");
    for (int i = 0; i < 2; i++) begin
      line_on <= 0;
      xf(1, i ? `RWC_PHY_CTL : `RWC_PWR_CTL, i ? 32'h0000_8000 : 32'h0000_0400);
      xf(0, i ? `RWC_PHY_CTL : `RWC_PWR_CTL, 0);
      chk(q[i ? 15 : 10], 1);
      chk({mac_rst, phy_rst}, 2'b01);
      repeat (PHYR + 5) @(posedge pclk);
      xf(0, i ? `RWC_PHY_CTL : `RWC_PWR_CTL, 0);
      chk(q[i ? 15 : 10], 0);
      chk(tx_hold, 1);
      line_on <= 1;
      repeat (15) @(posedge pclk);
      chk(tx_hold, 0);
    end
    xf(1, `RWC_PHY_CTL, 32'h0000_0800);
    repeat (3) @(posedge pclk);
    chk(phy_power_down, 1);
    xf(1, `RWC_PHY_CTL, 0);
    repeat (2) @(posedge pclk);
    chk({phy_rst, phy_power_down}, 2'b10);
    $display("test 3 done");
    xf(1, `RWC_INT_EN, 1);
    for (int i = 0; i < 3; i++) begin
      xf(1, `RWC_PWR_CTL, cfg[i]);
      frame_req <= 1;
      repeat (6) @(posedge pclk);
      frame_req <= 0;
      chk(host_irq, 1);
      chk(pme_pin, i < 2);
      xf(0, `RWC_PWR_CTL, 0);
      chk(q[5:4], 2'b10);
      xf(1, `RWC_BYTE_TST, $urandom);
      t0 = cyc;
      poll;
      chk(cyc - t0 <= WAKE + 6, 1);
      repeat (PUL) @(posedge pclk);
      if (i == 1) chk(plen, PUL);
      xf(1, `RWC_INTERRUPT_STATUS_REG, 1);
      xf(0, `RWC_INTERRUPT_STATUS_REG, 0);
      chk(q[0], 1);
      xf(1, `RWC_PWR_CTL, 32'h0000_0232);
      repeat (2) @(posedge pclk);
      chk(pme_pin, 0);
      xf(1, `RWC_INTERRUPT_STATUS_REG, 1);
      repeat (2) @(posedge pclk);
      chk(host_irq, 0);
    end
    $display("test 4 done");
    line_on <= 0;
    repeat (12) @(posedge pclk);
    xf(1, `RWC_PHY_MODE, 32'h0000_2000);
    repeat (4) @(posedge pclk);
    chk({phy_power_down, phy_tx_en}, 2'b10);
    xf(1, `RWC_PHY_MSK, 32'h0000_0002);
    xf(1, `RWC_PWR_CTL, 32'h0000_2102);
    line_on <= 1;
    repeat (8) @(posedge pclk);
    chk({pme_pin, phy_power_down, host_irq}, 3'b101);
    xf(1, `RWC_BYTE_TST, 0);
    t0 = cyc;
    poll;
    xf(0, `RWC_PWR_CTL, 0);
    chk(q[5:4], 2'b01);
    xf(0, `RWC_PHY_INT, 0);
    chk(q[1], 1);
    xf(1, `RWC_PHY_MODE, 0);
    xf(1, `RWC_PWR_CTL, 32'h0000_0130);
    repeat (2) @(posedge pclk);
    chk(pme_pin, 0);
    $display("test 5 done");
    strap_pins <= $urandom;
    reset_pin_n <= 0;
    repeat (8) @(posedge pclk);
    chk({pll_rst, phy_rst}, 2'b11);
    reset_pin_n <= 1;
    t0 = cyc;
    xf(0, `RWC_PWR_CTL, 0);
    chk(q[0], 0);
    poll;
    chk(cyc - t0 >= 100 && cyc - t0 <= 120, 1);
    xf(0, `RWC_STRAP, 0);
    chk(q[3:0], strap_pins);
    $display("test 6 done");
    results;
  end
endmodule // rwc_top_tb
